// [src/trxm_monitor.sv]
// ----------------------------------------------------------------------------
// trxm_monitor: receive error counters and event status words
// ----------------------------------------------------------------------------
// host reads registers over an asynchronous 8-bit parallel read port.
// framer events arrive on sys_clk; host pins are synchronised first.
// masks are ports; no mask registers here.
// address must stay steady through a read.
// events are sys_clk strobes or levels.
// counters hold during reads; status clears at read end.
//
// Functional notes
// - count bipolar violations, low byte readable
// - checksum error count high byte register
// - checksum error count low byte register
// - terminal sync change sets status bit
// - multiframe sync change sets bit; bit5 unused
// - all-ones start or end sets bit
// - signal loss change sets status bit
// - two framing errors in six sets bit
// - transmit slip sets status bit
// - receive slip sets status bit
// - framing error sets bit only in sync
// - crc-6 mismatch sets status bit
// - yellow alarm sets status bit
// - reframe with moved alignment sets bit
// - bipolar violation sets bit, not b8zs
// - prbs bit error sets status bit
// - density violation sets bit without b8zs
// - with b8zs, eight zeros set bit
// - reading a status word clears it
`timescale 1ns/1ps

module trxm_monitor
   import trxm_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int ADR_W = 8
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   // host parallel port
   input  wire logic             cpu_cs_n,
   input  wire logic             cpu_rd_n,
   input  wire logic [ADR_W-1:0] cpu_addr,
   output logic      [7:0]       cpu_data_out,
   output logic                  cpu_data_oe,
   // framer and decoder events
   input  wire trxm_event_s      events,
   input  wire trxm_bit_s        line_bit,
   input  wire logic             b8zs_enable,
   // event masks, 1 lets the event through
   input  wire logic [7:0]       mask_word_zero,
   input  wire logic [7:0]       mask_word_one
);

   if (CNT_W != 16 || ADR_W < 5) begin : g_bad_params
      $error("trxm_monitor: unsupported CNT_W or ADR_W");
   end

   // ------------------------------------------------------------------------
   // host pin synchronisers
   // ------------------------------------------------------------------------
   logic [ADR_W+1:0] pin_meta_q;
   logic [ADR_W+1:0] pin_sync_q;
   logic             rd_act_q;
   logic             rd_act;
   logic             rd_start;
   logic             rd_end;
   logic [ADR_W-1:0] adr_s;

   // two stages on every pin; a read is seen late
   // idle high at reset, so no false read start
   // address rides with the strobes; it is stable through any read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta_q <= '1;
         pin_sync_q <= '1;
      end else begin
         pin_meta_q <= {cpu_cs_n, cpu_rd_n, cpu_addr};
         pin_sync_q <= pin_meta_q;
      end
   end

   // strobe decode and one-cycle edge marks
   assign rd_act   = !pin_sync_q[ADR_W+1] && !pin_sync_q[ADR_W];
   assign adr_s    = pin_sync_q[ADR_W-1:0];
   assign rd_start = rd_act && !rd_act_q;
   assign rd_end   = !rd_act && rd_act_q;

   // last strobe state, idle after reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_act_q <= 1'b0;
      end else begin
         rd_act_q <= rd_act;
      end
   end

   // ------------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------------
   // one compare per offset, shared by mux and clear
   function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ADR_W'(ofs));
   endfunction : hit

   logic [ADR_W-1:0] rd_adr_q;
   logic             sel_lv_low;
   logic             sel_chk_high;
   logic             sel_chk_low;
   logic             sel_stat0;
   logic             sel_stat1;
   logic             sel_any;

   // one-hot selects from the synchronised address
   assign sel_lv_low   = hit(adr_s, TRXM_OFS_LV_LOW);
   assign sel_chk_high = hit(adr_s, TRXM_OFS_CHK_HIGH);
   assign sel_chk_low  = hit(adr_s, TRXM_OFS_CHK_LOW);
   assign sel_stat0    = hit(adr_s, TRXM_OFS_STAT0);
   assign sel_stat1    = hit(adr_s, TRXM_OFS_STAT1);
   // unmapped offsets read 00 with no enable
   assign sel_any      = sel_lv_low | sel_chk_high | sel_chk_low | sel_stat0 | sel_stat1;

   // ------------------------------------------------------------------------
   // error counters
   // ------------------------------------------------------------------------
   logic [CNT_W-1:0] lv_cnt_q;
   logic [CNT_W-1:0] chk_cnt_q;
   logic             lv_pend_q;
   logic             chk_pend_q;

   logic             lv_evt;
   logic             lv_inc;
   logic             chk_inc;

   // b8zs substitutions are coding, not errors
   assign lv_evt  = events.line_violation && !events.b8zs_substitution;
   // while a read is open the count is frozen; one event is kept pending
   // a second event in one read is lost; reads are short
   assign lv_inc  = !rd_act && (lv_evt || lv_pend_q);
   assign chk_inc = !rd_act && (events.checksum_error || chk_pend_q);

   // counters wrap at 16 bits
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lv_cnt_q   <= TRXM_CNT_RST;
         chk_cnt_q  <= TRXM_CNT_RST;
         lv_pend_q  <= 1'b0;
         chk_pend_q <= 1'b0;
      end else begin
         if (lv_inc) lv_cnt_q <= lv_cnt_q + 1'b1;
         if (chk_inc) chk_cnt_q <= chk_cnt_q + 1'b1;
         // pending slots fill only during a read
         lv_pend_q  <= rd_act && (lv_evt || lv_pend_q);
         chk_pend_q <= rd_act && (events.checksum_error || chk_pend_q);
      end
   end

   // ------------------------------------------------------------------------
   // event sources: level change detection and severe framing window
   // ------------------------------------------------------------------------
   logic [3:0]              lvl_q;
   logic [3:0]              lvl_now;
   logic [3:0]              lvl_chg;
   logic [TRXM_SEV_WIN-2:0] ferr_hist_q;
   logic                    sev_evt;
   logic                    dens_evt;

   // masks act later, at the status words
   assign lvl_now = {events.terminal_sync, events.multiframe_sync,
                     events.all_ones, events.signal_loss};
   // a rise or a fall of a level is one change
   assign lvl_chg = lvl_now ^ lvl_q;

   // this error plus at least one in the previous five framing bits
   assign sev_evt = events.framing_bit && events.framing_bit_error &&
                    ($countones(ferr_hist_q) >= TRXM_SEV_ERRS - 1);

   // levels start at zero, so a level already high after reset fires on the first sample
   // history moves on framing bits only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         lvl_q       <= '0;
         ferr_hist_q <= '0;
      end else begin
         lvl_q <= lvl_now;
         if (events.framing_bit)
            ferr_hist_q <= {ferr_hist_q[TRXM_SEV_WIN-3:0], events.framing_bit_error};
      end
   end

   // density monitor on the raw line bits
   trxm_density #(
      .MAX_N       (TRXM_DENS_MAX_N)
   ) u_density (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .line_bit    (line_bit),
      .b8zs_enable (b8zs_enable),
      .violation   (dens_evt)
   );

   // ------------------------------------------------------------------------
   // raw event vectors in status word layout
   // ------------------------------------------------------------------------
   logic [7:0] raw0;
   logic [7:0] raw1;

   // unused bits stay zero and never set
   always_comb begin
      raw0                = '0; // bit 5 stays unused
      raw0[TRXM_S0_TSYNC] = lvl_chg[3];
      raw0[TRXM_S0_MSYNC] = lvl_chg[2];
      raw0[TRXM_S0_ONES]  = lvl_chg[1];
      raw0[TRXM_S0_LOSS]  = lvl_chg[0];
      raw0[TRXM_S0_SEVF]  = sev_evt;
      raw0[TRXM_S0_TSLIP] = events.tx_slip;
      raw0[TRXM_S0_RSLIP] = events.rx_slip;

      // framing errors count only in terminal sync
      raw1                = '0;
      raw1[TRXM_S1_FERR]  = events.framing_bit && events.framing_bit_error &&
                            events.terminal_sync;
      raw1[TRXM_S1_CHK]   = events.checksum_error;
      raw1[TRXM_S1_RALM]  = events.remote_alarm;
      raw1[TRXM_S1_ALGN]  = events.reframe_done && events.alignment_moved;
      raw1[TRXM_S1_LVIO]  = lv_evt;
      raw1[TRXM_S1_TPAT]  = events.test_pattern_error;
      raw1[TRXM_S1_DENS]  = dens_evt;
   end

   // ------------------------------------------------------------------------
   // status words: set by unmasked events, cleared by the read that saw them
   // ------------------------------------------------------------------------
   logic [7:0] stat0_q;
   logic [7:0] stat1_q;
   logic [7:0] stat0_d;
   logic [7:0] stat1_d;

   logic [7:0] clr0;
   logic [7:0] clr1;
   logic       rd_was_stat0;
   logic       rd_was_stat1;

   // word of the read now ending, kept from its start
   assign rd_was_stat0 = hit(rd_adr_q, TRXM_OFS_STAT0);
   assign rd_was_stat1 = hit(rd_adr_q, TRXM_OFS_STAT1);
   // counter reads never touch the status words
   // only bits the host actually saw are cleared, so later events survive
   assign clr0    = (rd_end && rd_was_stat0) ? cpu_data_out : '0;
   assign clr1    = (rd_end && rd_was_stat1) ? cpu_data_out : '0;
   // set is ored last, so an event at the clear edge wins
   assign stat0_d = (stat0_q & ~clr0) | (raw0 & mask_word_zero);
   assign stat1_d = (stat1_q & ~clr1) | (raw1 & mask_word_one);

   // reset drops every pending event
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stat0_q <= TRXM_STAT_RST;
         stat1_q <= TRXM_STAT_RST;
      end else begin
         stat0_q <= stat0_d;
         stat1_q <= stat1_d;
      end
   end

   // ------------------------------------------------------------------------
   // read data: captured once at the start of the read and held
   // ------------------------------------------------------------------------
   logic [7:0] rd_mux;
   logic       oe_q;

   // selects are one-hot, so the order is moot
   assign rd_mux = sel_lv_low   ? lv_cnt_q[7:0] :
                   sel_chk_high ? chk_cnt_q[15:8] :
                   sel_chk_low  ? chk_cnt_q[7:0] :
                   sel_stat0    ? stat0_q :
                   sel_stat1    ? stat1_q : TRXM_RD_NONE;

   // capture at start keeps the byte steady for the host
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_data_out <= TRXM_RD_NONE;
         rd_adr_q     <= '0;
         oe_q         <= 1'b0;
      end else begin
         if (rd_start) begin
            cpu_data_out <= rd_mux;
            // address kept for the clear at read end
            rd_adr_q     <= adr_s;
         end
         // enable drops once the strobe is gone
         oe_q <= rd_act && (rd_start ? sel_any : oe_q);
      end
   end

   // enable only for mapped reads
   assign cpu_data_oe = oe_q;

endmodule : trxm_monitor

// [src/trxm_pkg.sv]
// ----------------------------------------------------------------------------
// trxm_pkg: shared constants and carriers of the receive monitor block
// ----------------------------------------------------------------------------
// register offsets, status bit positions, counter and density constants.
// assumes an 8-bit parallel host port and one receive-side clock.
package trxm_pkg;

   // register offsets on the host port
   localparam logic [7:0] TRXM_OFS_LV_LOW   = 8'h17;
   localparam logic [7:0] TRXM_OFS_CHK_HIGH = 8'h18;
   localparam logic [7:0] TRXM_OFS_CHK_LOW  = 8'h19;
   localparam logic [7:0] TRXM_OFS_STAT0    = 8'h1b;
   localparam logic [7:0] TRXM_OFS_STAT1    = 8'h1c;

   // status word zero bit positions (bit 5 unused)
   localparam int TRXM_S0_TSYNC = 7;
   localparam int TRXM_S0_MSYNC = 6;
   localparam int TRXM_S0_ONES  = 4;
   localparam int TRXM_S0_LOSS  = 3;
   localparam int TRXM_S0_SEVF  = 2;
   localparam int TRXM_S0_TSLIP = 1;
   localparam int TRXM_S0_RSLIP = 0;

   // status word one bit positions (bit 0 unused here)
   localparam int TRXM_S1_FERR  = 7;
   localparam int TRXM_S1_CHK   = 6;
   localparam int TRXM_S1_RALM  = 5;
   localparam int TRXM_S1_ALGN  = 4;
   localparam int TRXM_S1_LVIO  = 3;
   localparam int TRXM_S1_TPAT  = 2;
   localparam int TRXM_S1_DENS  = 1;

   // reset values
   localparam logic [7:0]  TRXM_STAT_RST = 8'h00;
   localparam logic [15:0] TRXM_CNT_RST  = 16'h0000;
   localparam logic [7:0]  TRXM_RD_NONE  = 8'h00;

   // severe framing: 2 errors inside a window of 6 framing bits
   localparam int TRXM_SEV_WIN  = 6;
   localparam int TRXM_SEV_ERRS = 2;

   // pulse density figures
   localparam int TRXM_DENS_ZEROS      = 16;
   localparam int TRXM_DENS_ZEROS_B8ZS = 8;
   localparam int TRXM_DENS_MAX_N      = 23;
   localparam int TRXM_DENS_STEP       = 8;

   // event strobes and state levels delivered by the framer and decoder
   typedef struct packed {
      logic terminal_sync;       // level: terminal frame sync held
      logic multiframe_sync;     // level: multiframe sync held
      logic all_ones;            // level: received all-ones condition
      logic signal_loss;         // level: analog or digital loss of signal
      logic framing_bit;         // pulse: a framing bit was checked
      logic framing_bit_error;   // with framing_bit: that bit was wrong
      logic tx_slip;             // pulse: transmit buffer slipped a frame
      logic rx_slip;             // pulse: receive buffer slipped a frame
      logic checksum_error;      // pulse: local crc-6 mismatch
      logic remote_alarm;        // pulse: yellow alarm detected
      logic reframe_done;        // pulse: reframe finished
      logic alignment_moved;     // with reframe_done: new alignment differs
      logic line_violation;      // pulse: bipolar violation seen
      logic b8zs_substitution;   // with line_violation: it was intentional
      logic test_pattern_error;  // pulse: prbs bit error on tested channel
   } trxm_event_s;

   // received line bit stream for the density monitor
   typedef struct packed {
      logic valid;               // pulse: one line bit this cycle
      logic one;                 // with valid: the bit was a mark
   } trxm_bit_s;

endpackage : trxm_pkg

// [src/trxm_density.sv]
// ----------------------------------------------------------------------------
// trxm_density: pulse density violation detector
// ----------------------------------------------------------------------------
// watches the received line bits and pulses on a density violation.
// assumes bits arrive on sys_clk as one-cycle valid strobes.
`timescale 1ns/1ps

module trxm_density
   import trxm_pkg::*;
#(
   parameter int MAX_N = TRXM_DENS_MAX_N
) (
   // clock and reset
   input  wire logic      sys_clk,
   input  wire logic      nrst,
   // line side
   input  wire trxm_bit_s line_bit,
   input  wire logic      b8zs_enable,
   // result
   output logic           violation
);

   localparam int AW = 8;
   localparam logic [AW-1:0] AGE_MAX = '1;

   if (MAX_N < 1 || TRXM_DENS_STEP * (MAX_N + 1) > 254) begin : g_bad_max_n
      $error("trxm_density: MAX_N out of range");
   end

   // ------------------------------------------------------------------------
   // zero run counter
   // ------------------------------------------------------------------------
   logic [AW-1:0] zrun_q;
   logic [AW-1:0] zrun_d;
   logic [AW-1:0] zrun_lim;
   logic          zrun_hit;

   assign zrun_lim = b8zs_enable ? AW'(TRXM_DENS_ZEROS_B8ZS) : AW'(TRXM_DENS_ZEROS);
   assign zrun_d   = line_bit.one ? '0 : ((zrun_q == AGE_MAX) ? zrun_q : zrun_q + 1'b1);
   // fire once, on the bit that completes the run
   assign zrun_hit = line_bit.valid && !line_bit.one && (zrun_d == zrun_lim);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) zrun_q <= '0;
      else if (line_bit.valid) zrun_q <= zrun_d;
   end

   // ------------------------------------------------------------------------
   // ages of the last MAX_N marks; age k too old means fewer than k ones
   // ------------------------------------------------------------------------
   // starting all ages at zero avoids a false alarm straight after reset
   logic [AW-1:0] age_q [1:MAX_N];
   logic [AW-1:0] age_d [1:MAX_N];
   logic [MAX_N:1] win_hit;

   genvar k;
   generate
      for (k = 1; k <= MAX_N; k++) begin : g_age
         logic [AW-1:0] older;
         if (k == 1) begin : g_first
            assign older = '0;
         end else begin : g_rest
            assign older = age_q[k-1];
         end
         assign age_d[k] = line_bit.one ? ((older == AGE_MAX) ? older : older + 1'b1)
                                        : ((age_q[k] == AGE_MAX) ? age_q[k] : age_q[k] + 1'b1);
         // mark k just left the last 8(k+1) bits: fewer than k ones
         assign win_hit[k] = line_bit.valid && !b8zs_enable &&
                             (age_d[k] == AW'(TRXM_DENS_STEP * (k + 1) + 1));
         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) age_q[k] <= '0;
            else if (line_bit.valid) age_q[k] <= age_d[k];
         end
      end
   endgenerate

   assign violation = zrun_hit | (|win_hit);

endmodule : trxm_density

// [testbench/trxm_monitor_assertions.sv]
// checker of the receive monitor host read port
// sees only the top ports; bound to trxm_monitor at the foot of this file
`timescale 1ns/1ps

module trxm_monitor_checker
   import trxm_pkg::*;
#(
   parameter int ADR_W = 8
) (
   // clock and reset
   input wire logic             sys_clk,
   input wire logic             nrst,
   // host port
   input wire logic             cpu_cs_n,
   input wire logic             cpu_rd_n,
   input wire logic [ADR_W-1:0] cpu_addr,
   input wire logic [7:0]       cpu_data_out,
   input wire logic             cpu_data_oe
);
   // ---------------------------------------------------------------
   // read port relations
   // ---------------------------------------------------------------
   // pin decode; the host holds the address until the enable drops
   wire sel    = !cpu_cs_n && !cpu_rd_n;
   wire mapped = (cpu_addr == TRXM_OFS_LV_LOW) || (cpu_addr == TRXM_OFS_CHK_HIGH) ||
                 (cpu_addr == TRXM_OFS_CHK_LOW) || (cpu_addr == TRXM_OFS_STAT0) ||
                 (cpu_addr == TRXM_OFS_STAT1);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // a mapped read held long enough to cover the strobe sync
   sequence s_sel_mapped; sel && mapped; endsequence
   sequence s_long_read; s_sel_mapped [*6]; endsequence

   property p_mapped_read; s_long_read |-> cpu_data_oe; endproperty
   property p_unmapped_quiet; cpu_data_oe |-> mapped; endproperty
   property p_oe_cause; $rose(cpu_data_oe) |-> $past(sel, 2); endproperty
   property p_oe_hold; cpu_data_oe && sel |=> cpu_data_oe; endproperty
   property p_oe_release; cpu_data_oe && $rose(cpu_rd_n) |-> ##[2:5] !cpu_data_oe; endproperty
   property p_idle_quiet; cpu_cs_n [*6] |-> !cpu_data_oe; endproperty
   property p_data_quiet; $changed(cpu_data_out) |-> $past(sel, 1) && $past(sel, 2); endproperty
   property p_unused_bits;
      cpu_data_oe |-> !(cpu_addr == TRXM_OFS_STAT0 && cpu_data_out[5]) &&
                      !(cpu_addr == TRXM_OFS_STAT1 && cpu_data_out[0]);
   endproperty
   property p_reset_quiet; !$past(nrst) |-> cpu_data_out == TRXM_RD_NONE && !cpu_data_oe; endproperty

   a_mapped_read: assert property (p_mapped_read)
      else $error("mapped read got no data enable");
   a_unmapped_quiet: assert property (p_unmapped_quiet)
      else $error("data enable on unmapped address");
   a_oe_cause: assert property (p_oe_cause)
      else $error("data enable rose without a read");
   a_oe_hold: assert property (p_oe_hold)
      else $error("data enable dropped during read");
   a_oe_release: assert property (p_oe_release)
      else $error("data enable held after read end");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("data enable while not selected");
   a_data_quiet: assert property (p_data_quiet)
      else $error("read data changed outside a read");
   a_unused_bits: assert property (p_unused_bits)
      else $error("unused status bit read as one");
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("read port not idle after reset");
endmodule : trxm_monitor_checker

bind trxm_monitor trxm_monitor_checker #(.ADR_W(ADR_W)) chk_u (
   .sys_clk(sys_clk), .nrst(nrst), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n),
   .cpu_addr(cpu_addr), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe));

// [testbench/trxm_host_model.sv]
// host processor model for the receive monitor read port
// assumes the bench calls read only after reset has been released
`timescale 1ns/1ps

module trxm_host_model
   import trxm_pkg::*;
(
   // clock
   input  wire logic       sys_clk,
   // host pins
   output logic            cpu_cs_n,
   output logic            cpu_rd_n,
   output logic      [7:0] cpu_addr,
   // answer
   input  wire logic [7:0] cpu_data_out,
   input  wire logic       cpu_data_oe
);
   // ---------------------------------------------------------------
   // read cycle
   // ---------------------------------------------------------------
   // strobes idle high, address 00 at time zero
   initial begin
      cpu_cs_n = 1'b1;
      cpu_rd_n = 1'b1;
      cpu_addr = 8'h00;
   end

   // reading a status word is how software acknowledges it
   // pins held 7 edges, covering the slow sync phase; ok low if no enable
   task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int n;
      ok = 1'b0;
      d = TRXM_RD_NONE;
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_cs_n <= 1'b0;
      cpu_rd_n <= 1'b0;
      for (n = 0; n < 7; n++) begin
         @(posedge sys_clk);
         if (cpu_data_oe === 1'b1 && !ok) begin
            ok = 1'b1;
            d = cpu_data_out;
         end
      end
      cpu_cs_n <= 1'b1;
      cpu_rd_n <= 1'b1;
      // address kept until the enable drops, then the 3-cycle gap
      for (n = 0; n < 8 && cpu_data_oe !== 1'b0; n++)
         @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
   endtask : read
endmodule : trxm_host_model

// [testbench/test_t1_rx_error_counters_and_interrupts.sv]
// self-checking bench of the receive monitor block
// assumes trxm_host_model drives the host pins; events come from here
`timescale 1ns/1ps

module test_t1_rx_error_counters_and_interrupts
   import trxm_pkg::*;
;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cpu_cs_n;
   logic        cpu_rd_n;
   logic [7:0]  cpu_addr;
   logic [7:0]  cpu_data_out;
   logic        cpu_data_oe;
   trxm_event_s ev;
   trxm_bit_s   lb;
   logic        b8zs;
   logic [7:0]  m0;
   logic [7:0]  m1;
   logic [7:0]  rd;
   bit          ok;
   int          miscompares = 0;
   int          checks = 0;
   logic [7:0]  adrs [5] = '{TRXM_OFS_LV_LOW, TRXM_OFS_CHK_HIGH, TRXM_OFS_CHK_LOW,
                             TRXM_OFS_STAT0, TRXM_OFS_STAT1};
   // event vector, then word zero and word one expected afterwards
   logic [30:0] tbl [14] = '{{15'h4600, 8'h80, 8'h80}, {15'h0600, 8'h04, 8'h00},
      {15'h2000, 8'h40, 8'h00}, {15'h1000, 8'h10, 8'h00}, {15'h0800, 8'h08, 8'h00},
      {15'h0100, 8'h02, 8'h00}, {15'h0080, 8'h01, 8'h00}, {15'h0040, 8'h00, 8'h40},
      {15'h0020, 8'h00, 8'h20}, {15'h0018, 8'h00, 8'h10}, {15'h0010, 8'h00, 8'h00},
      {15'h0004, 8'h00, 8'h08}, {15'h0006, 8'h00, 8'h00}, {15'h0001, 8'h00, 8'h04}};

   always #5 sys_clk = ~sys_clk;

   trxm_monitor dut_u (
      .sys_clk(sys_clk), .nrst(nrst), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n),
      .cpu_addr(cpu_addr), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
      .events(ev), .line_bit(lb), .b8zs_enable(b8zs),
      .mask_word_zero(m0), .mask_word_one(m1));

   trxm_host_model host_u (
      .sys_clk(sys_clk), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n),
      .cpu_addr(cpu_addr), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // a read that never saw the enable ends the run
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host_u.read(a, rd, ok);
      check({7'h00, ok}, 8'h01);
      if (!ok)
         report_and_stop();
      else
         check(rd, exp);
   endtask : rd_chk

   task automatic pulse(input logic [14:0] v, input int n);
      repeat (n) @(posedge sys_clk) ev <= trxm_event_s'(v);
      @(posedge sys_clk) ev <= '0;
   endtask : pulse

   // line bits on every other cycle
   task automatic send(input int n, input logic one);
      repeat (n) begin
         @(posedge sys_clk) lb <= '{valid: 1'b1, one: one};
         @(posedge sys_clk) lb <= '{valid: 1'b0, one: 1'b0};
      end
   endtask : send

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      ev = '0;
      lb = '0;
      b8zs = 1'b0;
      m0 = 8'hff;
      m1 = 8'hff;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      foreach (adrs[i]) rd_chk(adrs[i], 8'h00);
      host_u.read(8'h1a, rd, ok);
      check({7'h00, ok}, 8'h00);
      $display("test reset values done");
      // each read also clears what it showed
      foreach (tbl[i]) begin
         pulse(tbl[i][30:16], 1);
         rd_chk(TRXM_OFS_STAT0, tbl[i][15:8]);
         rd_chk(TRXM_OFS_STAT1, tbl[i][7:0]);
      end
      $display("test event table done");
      @(posedge sys_clk) m0 <= 8'h00;
      m1 <= 8'h00;
      pulse(15'h01a0, 1);
      rd_chk(TRXM_OFS_STAT0, 8'h00);
      rd_chk(TRXM_OFS_STAT1, 8'h00);
      @(posedge sys_clk) m0 <= 8'hff;
      m1 <= 8'hff;
      $display("test masks done");
      rd_chk(TRXM_OFS_LV_LOW, 8'h01);
      rd_chk(TRXM_OFS_CHK_HIGH, 8'h00);
      rd_chk(TRXM_OFS_CHK_LOW, 8'h01);
      pulse(15'h0044, 255);
      rd_chk(TRXM_OFS_LV_LOW, 8'h00);
      rd_chk(TRXM_OFS_CHK_HIGH, 8'h01);
      rd_chk(TRXM_OFS_CHK_LOW, 8'h00);
      rd_chk(TRXM_OFS_STAT1, 8'h48);
      // events land while a counter read is active
      fork
         host_u.read(TRXM_OFS_LV_LOW, rd, ok);
         begin
            repeat (4) @(posedge sys_clk);
            pulse(15'h0005, 1);
         end
      join
      check(rd, 8'h00);
      rd_chk(TRXM_OFS_STAT1, 8'h0c);
      rd_chk(TRXM_OFS_LV_LOW, 8'h01);
      // event on the clearing edge survives the read
      pulse(15'h0004, 1);
      fork
         host_u.read(TRXM_OFS_STAT1, rd, ok);
         begin
            repeat (9) @(posedge sys_clk);
            pulse(15'h0004, 1);
         end
      join
      check(rd, 8'h08);
      rd_chk(TRXM_OFS_STAT1, 8'h08);
      $display("test counters done");
      @(posedge sys_clk) b8zs <= 1'b1;
      send(7, 1'b0);
      rd_chk(TRXM_OFS_STAT1, 8'h00);
      send(1, 1'b0);
      rd_chk(TRXM_OFS_STAT1, 8'h02);
      @(posedge sys_clk) b8zs <= 1'b0;
      send(1, 1'b1);
      send(14, 1'b0);
      rd_chk(TRXM_OFS_STAT1, 8'h00);
      send(2, 1'b0);
      rd_chk(TRXM_OFS_STAT1, 8'h02);
      // one mark in the last 24 bits, zero run only 11
      send(23, 1'b1);
      send(12, 1'b0);
      send(1, 1'b1);
      send(10, 1'b0);
      rd_chk(TRXM_OFS_STAT1, 8'h00);
      send(1, 1'b0);
      rd_chk(TRXM_OFS_STAT1, 8'h02);
      $display("test density done");
      report_and_stop();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end
endmodule : test_t1_rx_error_counters_and_interrupts
